// ==== hw/pwr_rst_defines.vh ====
// Purpose: Controller constants
// Assumes: 100 MHz clk
// Notes:   Power modes, reset cause codes and wake source bit positions
`ifndef PWR_RST_DEFINES_VH
`define PWR_RST_DEFINES_VH

// Power modes
`define MODE_ACTIVE      3'h0
`define MODE_SLEEP_PG    3'h1
`define MODE_SLEEP_CG    3'h2
`define MODE_DEEP_SLEEP  3'h3
`define MODE_WAKING      3'h4

// Reset cause codes
`define CAUSE_NONE       4'h0
`define CAUSE_POR        4'h1
`define CAUSE_CHIP_EN    4'h2
`define CAUSE_BROWNOUT   4'h3
`define CAUSE_THERMAL    4'h4
`define CAUSE_DEEP_SLEEP_EXIT_RESET_EXIT  4'h5
`define CAUSE_WATCHDOG   4'h6
`define CAUSE_SYS        4'h7
`define CAUSE_DEBUG      4'h8

// Sleep wake source bits
`define SW_WLAN          0
`define SW_BT            1
`define SW_IPC           2
`define SW_TIMER         3
`define SW_PMC_TIMER     4
`define SW_UART          5
`define SW_LOG_UART      6
`define SW_GPIO          7
`define SW_ETH           8
`define SW_TOUCH         9
`define SW_CAN           10
`define SW_INDEPENDENT_WATCHDOG          11
`define SW_ADC           12
`define SW_SDIO          13
`define SW_USB           14
`define SLEEP_SRC_W      15

// Deep sleep wake source bits
`define DW_ALWAYS_ON_TIMER     0
`define DW_WAKE_PINS     1
`define DW_RTC           2
`define DW_BROWNOUT      3
`define DW_CHIP_EN       4
`define DEEP_SRC_W       5

// Serial wake FIFO depths, in bytes
`define UART_WAKE_DEPTH  64
`define LOG_WAKE_DEPTH   32

// Reset scope vector bits
`define SC_WHOLE_CHIP    0
`define SC_SYS_PERIPH    1
`define SC_INDEP_WDG     2
`define SC_I2C_PINMUX    3
`define SC_APP_CORE      4
`define SC_NET_CORE      5
`define SCOPE_W          6

// Reset release stretch, in clock cycles, and PLL count
`define RST_SYNC_STAGES  2
`define NUM_PLLS         2

`endif

// ==== hw/reset_release_sync.v ====
// Purpose: Asynchronous assert, synchronous release of one domain reset
// Assumes: hold is active high
// Notes:   Output is active low
module reset_release_sync (
   input  wire clk,
   input  wire reset_n,
   input  wire hold,
   output wire dom_reset_n
);
   reg [1:0] sync_r;
   wire      clr_n;

   assign clr_n = reset_n & ~hold;

   always @(posedge clk or negedge clr_n) begin
      if (!clr_n) begin
         sync_r <= 2'h0;
      end else begin
         sync_r <= {sync_r[0], 1'b1};
      end
   end

   assign dom_reset_n = sync_r[1];
endmodule // reset_release_sync

// ==== hw/wake_byte_keep.v ====
// Purpose: Counts wake-command bytes kept in a serial receive FIFO
// Assumes: byte_valid is a one-cycle pulse per received byte
// Notes:   Bytes past depth are lost
module wake_byte_keep #(
   parameter DEPTH = 64
) (
   input  wire       clk,
   input  wire       reset_n,
   input  wire       arm,
   input  wire       byte_valid,
   output reg        byte_keep,
   output reg  [6:0] kept_cnt_r,
   output reg        overflow_r
);
   localparam [6:0] DEPTH_C = DEPTH;

   always @* begin
      byte_keep = byte_valid & arm & (kept_cnt_r < DEPTH_C);
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         kept_cnt_r <= 7'h00;
         overflow_r <= 1'b0;
      end else if (!arm) begin
         kept_cnt_r <= 7'h00;
         overflow_r <= 1'b0;
      end else if (byte_valid) begin
         if (kept_cnt_r < DEPTH_C) begin
            kept_cnt_r <= kept_cnt_r + 7'h01;
         end else begin
            overflow_r <= 1'b1;
         end
      end
   end
endmodule // wake_byte_keep

// ==== hw/power_reset_wake_control.v ====
// Purpose: Power mode sequencing, wake gating and reset scope routing
// Assumes: Supervisor comparator outputs and reset requests are async
// Notes:   Status outputs registered
`include "pwr_rst_defines.vh"

module power_reset_wake_control (
   input  wire        clk,
   input  wire        reset_n,
   input  wire        rtc_reset_n,
   input  wire        supply_above_por_hi,
   input  wire        supply_below_por_lo,
   input  wire        supply_below_bod_fall,
   input  wire        supply_above_bod_rise,
   input  wire        chip_enable,
   input  wire        brownout_disable,
   input  wire        brownout_irq_mode,
   input  wire        chip_en_irq_mode,
   input  wire        thermal_trip,
   input  wire        watchdog_req,
   input  wire        indep_watchdog_req,
   input  wire        sys_reset_req,
   input  wire        net_sys_reset_req,
   input  wire        net_watchdog_req,
   input  wire        net_reset_core_only,
   input  wire        debug_req,
   input  wire        debug_from_net,
   input  wire        debug_reset_other,
   input  wire [1:0]  sleep_req,
   input  wire [14:0] sleep_wake_in,
   input  wire [14:0] sleep_wake_en,
   input  wire [3:0]  ipc_wake_src,
   input  wire [7:0]  timer_wake_in,
   input  wire [4:0]  deep_wake_in,
   input  wire [4:0]  deep_wake_en,
   input  wire        uart_rx_byte,
   input  wire        log_rx_byte,
   input  wire [15:0] module_clk_gate,
   input  wire        cpu_pll_sel,
   input  wire        hsp_pll_sel,
   output reg  [2:0]  power_mode_r,
   output reg         brownout_irq_r,
   output reg  [3:0]  last_cause_r,
   output reg         cold_boot_r,
   output reg         core_power_on_r,
   output reg         core_clk_on_r,
   output reg         sram_retain_r,
   output reg         sram_power_on_r,
   output reg         soc_power_on_r,
   output reg         system_on_domain_power_on_r,
   output reg  [15:0] module_clk_en_r,
   output reg         cpu_clk_src_r,
   output reg         hsp_clk_src_r,
   output wire        uart_byte_keep,
   output wire        log_byte_keep,
   output wire        uart_wake_overflow,
   output wire        log_wake_overflow,
   output wire        whole_chip_reset_n,
   output wire        sys_periph_reset_n,
   output wire        indep_wdg_reset_n,
   output wire        i2c_pinmux_reset_n,
   output wire        app_core_reset_n,
   output wire        net_core_reset_n,
   output wire        rtc_dom_reset_n
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers: every async level passes two flops
   localparam NSYNC = 51;
   wire [NSYNC-1:0] async_in;
   reg  [NSYNC-1:0] meta_r;
   reg  [NSYNC-1:0] sync_r;

   assign async_in = {supply_above_por_hi, supply_below_por_lo,
                      supply_below_bod_fall, supply_above_bod_rise,
                      chip_enable, thermal_trip, watchdog_req,
                      indep_watchdog_req, sys_reset_req, net_sys_reset_req,
                      net_watchdog_req, debug_req, sleep_wake_in,
                      ipc_wake_src, timer_wake_in, deep_wake_in,
                      uart_rx_byte, log_rx_byte, 5'h00};

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= {NSYNC{1'b0}};
         sync_r <= {NSYNC{1'b0}};
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   wire        s_por_hi    = sync_r[50];
   wire        s_por_lo    = sync_r[49];
   wire        s_bod_fall  = sync_r[48];
   wire        s_bod_rise  = sync_r[47];
   wire        s_chip_en   = sync_r[46];
   wire        s_thermal   = sync_r[45];
   wire        s_wdg       = sync_r[44];
   wire        s_independent_watchdog      = sync_r[43];
   wire        s_sys       = sync_r[42];
   wire        s_net_sys   = sync_r[41];
   wire        s_net_wdg   = sync_r[40];
   wire        s_dbg       = sync_r[39];
   wire [14:0] s_sleep_src = sync_r[38:24];
   wire [3:0]  s_ipc       = sync_r[23:20];
   wire [7:0]  s_timer     = sync_r[19:12];
   wire [4:0]  s_deep_src  = sync_r[11:7];
   wire        s_uart_b    = sync_r[6];
   wire        s_log_b     = sync_r[5];
   reg         uart_b_d_r;
   reg         log_b_d_r;

   ////////////////////////////////////////////////////////////////////////
   // Supervisor hold states
   reg por_hold_r;
   reg bod_hold_r;
   reg cen_hold_r;
   wire bod_active = ~brownout_disable;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         por_hold_r     <= 1'b1;
         bod_hold_r     <= 1'b0;
         cen_hold_r     <= 1'b0;
         brownout_irq_r <= 1'b0;
         uart_b_d_r     <= 1'b0;
         log_b_d_r      <= 1'b0;
      end else begin
         uart_b_d_r <= s_uart_b;
         log_b_d_r  <= s_log_b;
         if (s_por_lo) begin
            por_hold_r <= 1'b1;
         end else if (s_por_hi) begin
            por_hold_r <= 1'b0;
         end
         // Reset mode is the default because both controls reset low
         if (bod_active && !brownout_irq_mode && s_bod_fall) begin
            bod_hold_r <= 1'b1;
         end else if (bod_hold_r && s_bod_rise) begin
            bod_hold_r <= 1'b0;
         end
         // Level interrupt follows the comparator in interrupt mode
         brownout_irq_r <= bod_active & brownout_irq_mode & s_bod_fall;
         // Chip enable low shuts down unless it is a deep sleep wake pin
         if (!s_chip_en && !(chip_en_irq_mode &&
             power_mode_r == `MODE_DEEP_SLEEP)) begin
            cen_hold_r <= 1'b1;
         end else if (s_chip_en) begin
            cen_hold_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake gating
   function sleep_allowed;
      input [14:0] src;
      input [14:0] en;
      input [3:0]  ipc;
      input [7:0]  tmr;
      input        cg;
      reg   [14:0] m;
      begin
         m = src & en;
         m[`SW_IPC]   = en[`SW_IPC] & ipc[0];
         m[`SW_TIMER] = en[`SW_TIMER] & (|tmr[3:0]);
         m[`SW_SDIO]  = m[`SW_SDIO] & cg;
         m[`SW_USB]   = m[`SW_USB] & cg;
         sleep_allowed = |m;
      end
   endfunction

   // ipc bit 0: network core to application core; other bits ignored
   wire sleep_wake = sleep_allowed(s_sleep_src, sleep_wake_en, s_ipc,
                                   s_timer, power_mode_r == `MODE_SLEEP_CG);
   wire [4:0] deep_mask = s_deep_src & deep_wake_en;
   wire deep_wake = deep_mask[`DW_ALWAYS_ON_TIMER] | deep_mask[`DW_WAKE_PINS] |
                    deep_mask[`DW_RTC] | deep_mask[`DW_BROWNOUT] |
                    (deep_mask[`DW_CHIP_EN] & chip_en_irq_mode);

   ////////////////////////////////////////////////////////////////////////
   // Power mode sequencer
   reg  [2:0] mode_nxt;
   reg        deep_sleep_exit_reset_pulse_r;

   always @* begin
      mode_nxt = power_mode_r;
      case (power_mode_r)
         `MODE_ACTIVE: begin
            case (sleep_req)
               2'h1: mode_nxt = `MODE_SLEEP_PG;
               2'h2: mode_nxt = `MODE_SLEEP_CG;
               2'h3: mode_nxt = `MODE_DEEP_SLEEP;
               default: mode_nxt = `MODE_ACTIVE;
            endcase
         end
         `MODE_SLEEP_PG, `MODE_SLEEP_CG: begin
            if (sleep_wake) mode_nxt = `MODE_ACTIVE;
         end
         `MODE_DEEP_SLEEP: begin
            if (deep_wake) mode_nxt = `MODE_WAKING;
         end
         `MODE_WAKING: mode_nxt = `MODE_ACTIVE;
         default: mode_nxt = `MODE_ACTIVE;
      endcase
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         power_mode_r     <= `MODE_ACTIVE;
         deep_sleep_exit_reset_pulse_r     <= 1'b0;
         cold_boot_r      <= 1'b1;
         core_power_on_r  <= 1'b1;
         core_clk_on_r    <= 1'b1;
         sram_retain_r    <= 1'b0;
         sram_power_on_r  <= 1'b1;
         soc_power_on_r   <= 1'b1;
         system_on_domain_power_on_r <= 1'b1;
         module_clk_en_r  <= 16'hFFFF;
         cpu_clk_src_r    <= 1'b0;
         hsp_clk_src_r    <= 1'b0;
      end else begin
         power_mode_r <= mode_nxt;
         deep_sleep_exit_reset_pulse_r <= (power_mode_r == `MODE_DEEP_SLEEP) &&
                         (mode_nxt == `MODE_WAKING);
         if (power_mode_r == `MODE_WAKING) begin
            cold_boot_r <= 1'b1;
         end else if (mode_nxt == `MODE_ACTIVE &&
                      power_mode_r != `MODE_ACTIVE) begin
            cold_boot_r <= 1'b0;
         end
         core_power_on_r  <= (mode_nxt == `MODE_ACTIVE) ||
                             (mode_nxt == `MODE_SLEEP_CG);
         core_clk_on_r    <= (mode_nxt == `MODE_ACTIVE);
         sram_retain_r    <= (mode_nxt == `MODE_SLEEP_PG) ||
                             (mode_nxt == `MODE_SLEEP_CG);
         sram_power_on_r  <= (mode_nxt != `MODE_DEEP_SLEEP);
         soc_power_on_r   <= (mode_nxt != `MODE_DEEP_SLEEP) &&
                             (mode_nxt != `MODE_SLEEP_PG);
         system_on_domain_power_on_r <= (mode_nxt != `MODE_DEEP_SLEEP);
         module_clk_en_r  <= (mode_nxt == `MODE_ACTIVE) ?
                             ~module_clk_gate : 16'h0000;
         // CPU clock source changes only while the app core is halted in reset; HSP source follows hsp_pll_sel
         if (!app_core_reset_n) begin
            cpu_clk_src_r <= cpu_pll_sel;
         end
         hsp_clk_src_r <= hsp_pll_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset scope routing
   reg [`SCOPE_W-1:0] scope;
   reg [3:0]          cause;

   always @* begin
      scope = {`SCOPE_W{1'b0}};
      cause = `CAUSE_NONE;
      if (s_dbg) begin
         cause = `CAUSE_DEBUG;
         scope[`SC_APP_CORE] = ~debug_from_net | debug_reset_other;
         scope[`SC_NET_CORE] = debug_from_net | debug_reset_other;
         scope[`SC_SYS_PERIPH] = debug_reset_other;
      end
      if (s_net_sys || s_net_wdg) begin
         cause = s_net_sys ? `CAUSE_SYS : `CAUSE_WATCHDOG;
         scope[`SC_NET_CORE] = 1'b1;
         if (!net_reset_core_only) begin
            scope[`SC_SYS_PERIPH] = 1'b1;
            scope[`SC_INDEP_WDG]  = 1'b1;
            scope[`SC_APP_CORE]   = 1'b1;
         end
      end
      if (s_independent_watchdog || s_sys || s_wdg) begin
         cause = s_sys ? `CAUSE_SYS : `CAUSE_WATCHDOG;
         scope[`SC_SYS_PERIPH] = 1'b1;
         scope[`SC_INDEP_WDG]  = 1'b1;
         scope[`SC_APP_CORE]   = 1'b1;
         scope[`SC_NET_CORE]   = 1'b1;
      end
      if (s_thermal || bod_hold_r || deep_sleep_exit_reset_pulse_r) begin
         cause = bod_hold_r ? `CAUSE_BROWNOUT :
                 (s_thermal ? `CAUSE_THERMAL : `CAUSE_DEEP_SLEEP_EXIT_RESET_EXIT);
         scope[`SC_SYS_PERIPH] = 1'b1;
         scope[`SC_INDEP_WDG]  = 1'b1;
         scope[`SC_APP_CORE]   = 1'b1;
         scope[`SC_NET_CORE]   = 1'b1;
      end
      if (por_hold_r || cen_hold_r) begin
         cause = por_hold_r ? `CAUSE_POR : `CAUSE_CHIP_EN;
         scope = {`SCOPE_W{1'b1}};
      end
   end

   // Last cause stays sticky; power-on code is preset by reset
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         last_cause_r <= `CAUSE_POR;
      end else if (cause != `CAUSE_NONE) begin
         last_cause_r <= cause;
      end
   end

   wire [`SCOPE_W-1:0] dom_rst_n;
   genvar gi;
   generate
      for (gi = 0; gi < `SCOPE_W; gi = gi + 1) begin : g_dom
         reset_release_sync u_sync (
            .clk         (clk),
            .reset_n     (reset_n),
            .hold        (scope[gi]),
            .dom_reset_n (dom_rst_n[gi])
         );
      end
   endgenerate

   assign whole_chip_reset_n = dom_rst_n[`SC_WHOLE_CHIP];
   assign sys_periph_reset_n = dom_rst_n[`SC_SYS_PERIPH];
   assign indep_wdg_reset_n  = dom_rst_n[`SC_INDEP_WDG];
   assign i2c_pinmux_reset_n = dom_rst_n[`SC_I2C_PINMUX];
   assign app_core_reset_n   = dom_rst_n[`SC_APP_CORE];
   assign net_core_reset_n   = dom_rst_n[`SC_NET_CORE];

   // Clock domain reset ignores every other cause
   reset_release_sync u_rtc_sync (
      .clk         (clk),
      .reset_n     (rtc_reset_n),
      .hold        (1'b0),
      .dom_reset_n (rtc_dom_reset_n)
   );

   ////////////////////////////////////////////////////////////////////////
   // Serial receive wake byte keepers
   wire in_sleep = (power_mode_r == `MODE_SLEEP_PG) ||
                   (power_mode_r == `MODE_SLEEP_CG);

   wake_byte_keep #(.DEPTH(`UART_WAKE_DEPTH)) u_uart_keep (
      .clk        (clk),
      .reset_n    (reset_n),
      .arm        (in_sleep),
      .byte_valid (s_uart_b & ~uart_b_d_r),
      .byte_keep  (uart_byte_keep),
      .kept_cnt_r (),
      .overflow_r (uart_wake_overflow)
   );

   wake_byte_keep #(.DEPTH(`LOG_WAKE_DEPTH)) u_log_keep (
      .clk        (clk),
      .reset_n    (reset_n),
      .arm        (in_sleep),
      .byte_valid (s_log_b & ~log_b_d_r),
      .byte_keep  (log_byte_keep),
      .kept_cnt_r (),
      .overflow_r (log_wake_overflow)
   );

endmodule // power_reset_wake_control

// ==== verification/pwr_props.sv ====
// Purpose: Port-level controller checks
// Assumes: One clk domain
// Notes:   Sees only top ports
`include "pwr_rst_defines.vh"
module pwr_props (
   input logic       clk,
   input logic       reset_n,
   input logic       rtc_reset_n,
   input logic       supply_below_por_lo,
   input logic       supply_below_bod_fall,
   input logic       chip_enable,
   input logic       brownout_disable,
   input logic       brownout_irq_mode,
   input logic       hsp_pll_sel,
   input logic [2:0] power_mode_r,
   input logic       brownout_irq_r,
   input logic [3:0] last_cause_r,
   input logic       cold_boot_r,
   input logic       core_power_on_r,
   input logic       core_clk_on_r,
   input logic       sram_retain_r,
   input logic       sram_power_on_r,
   input logic       soc_power_on_r,
   input logic       system_on_domain_power_on_r,
   input logic       hsp_clk_src_r,
   input logic       whole_chip_reset_n,
   input logic       rtc_dom_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   a_deep_power_off:
      assert property (power_mode_r == `MODE_DEEP_SLEEP |-> !sram_power_on_r
         && !soc_power_on_r && !system_on_domain_power_on_r)
      else $error("deep sleep powered");
   a_sleep_pg_state:
      assert property (power_mode_r == `MODE_SLEEP_PG |-> !core_power_on_r
         && sram_retain_r)
      else $error("pg sleep wrong");
   a_sleep_cg_state:
      assert property (power_mode_r == `MODE_SLEEP_CG |-> core_power_on_r
         && !core_clk_on_r && sram_retain_r)
      else $error("cg sleep wrong");
   a_deep_exit_boot:
      assert property (power_mode_r == `MODE_DEEP_SLEEP ##1
         power_mode_r == `MODE_WAKING |=> power_mode_r == `MODE_ACTIVE
         && cold_boot_r && last_cause_r == `CAUSE_DEEP_SLEEP_EXIT_RESET_EXIT)
      else $error("no boot after deep");
   a_por_low_reset:
      assert property (supply_below_por_lo |-> ##[1:6] !whole_chip_reset_n)
      else $error("no power-on reset");
   a_bod_irq_mode:
      assert property ((supply_below_bod_fall && !brownout_disable
         && brownout_irq_mode)[*4] |-> brownout_irq_r)
      else $error("no brownout irq");
   a_chip_en_reset:
      assert property ((!chip_enable
         && power_mode_r != `MODE_DEEP_SLEEP)[*5] |-> !whole_chip_reset_n)
      else $error("no chip-enable reset");
   a_rtc_separate:
      assert property (rtc_reset_n[*4] |-> rtc_dom_reset_n)
      else $error("rtc reset shared");
   a_hsp_clk_sel:
      assert property ($stable(hsp_pll_sel)[*4] |-> hsp_clk_src_r
         == hsp_pll_sel)
      else $error("hsp source wrong");
endmodule // pwr_props

// ==== verification/supply_model.sv ====
// Purpose: Supply comparators
// Assumes: Abstract level from bench
// Notes:   Arbitrary units
module supply_model #(
   parameter int POR_LO   = 100,
   parameter int POR_HI   = 120,
   parameter int BOD_FALL = 200,
   parameter int BOD_RISE = 220
) (
   input  int   level,
   output logic por_hi,
   output logic por_lo,
   output logic bod_fall,
   output logic bod_rise
);
   timeunit 1ns;
   timeprecision 1ps;
   assign por_hi   = level > POR_HI;
   assign por_lo   = level < POR_LO;
   assign bod_fall = level < BOD_FALL;
   assign bod_rise = level > BOD_RISE;
endmodule // supply_model

// ==== verification/power_reset_wake_control_tb.sv ====
// Purpose: Self-checking bench
// Assumes: Inputs change on falling edge
// Notes:   Scopes checked from a table
`include "pwr_rst_defines.vh"
module power_reset_wake_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset_n, rtc_reset_n, chip_enable, cpu_pll_sel;
   logic        por_hi, por_lo, bod_fall, bod_rise, brownout_disable;
   logic        brownout_irq_mode, chip_en_irq_mode, hsp_pll_sel;
   logic        uart_rx_byte, log_rx_byte, uart_ovf, log_ovf;
   logic [1:0]  sleep_req;
   logic [14:0] sleep_wake_in, sleep_wake_en;
   logic [3:0]  ipc_wake_src, last_cause_r;
   logic [7:0]  timer_wake_in;
   logic [4:0]  deep_wake_in, deep_wake_en;
   logic [15:0] module_clk_gate, module_clk_en_r;
   logic [9:0]  rq;
   logic [2:0]  power_mode_r, prev_mode;
   logic        brownout_irq_r, cold_boot_r, core_power_on_r, core_clk_on_r;
   logic        sram_retain_r, sram_power_on_r, soc_power_on_r;
   logic        system_on_domain_power_on_r, cpu_clk_src_r, hsp_clk_src_r;
   logic        uart_byte_keep, log_byte_keep, rtc_dom_reset_n;
   wire  [5:0]  scope; // whole, sys, independent_watchdog, i2c, app, net
   int          level, num_errors, comparisons, kept_u, kept_l;
   logic [2:0]  mode_q[$];
   logic [9:0]  t_rq [8] = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h030,
                             10'h100, 10'h040, 10'h2C0};
   logic [3:0]  t_cs [8] = '{`CAUSE_THERMAL, `CAUSE_WATCHDOG,
      `CAUSE_WATCHDOG, `CAUSE_SYS, 4'h0, 4'h0, `CAUSE_DEBUG, `CAUSE_DEBUG};
   logic [5:0]  t_exp [8] = '{6'h20, 6'h24, 6'h24, 6'h24, 6'h32, 6'h24,
                              6'h21, 6'h20};
   logic [5:0]  t_msk [8] = '{6'h38, 6'h3C, 6'h3C, 6'h3C, 6'h33, 6'h3C,
                              6'h23, 6'h23};
   ////////////////////////////////////////////////////////////////////////
   supply_model sup_u (.level(level), .por_hi(por_hi), .por_lo(por_lo),
      .bod_fall(bod_fall), .bod_rise(bod_rise));
   power_reset_wake_control dut_u (.clk, .reset_n, .rtc_reset_n,
      .supply_above_por_hi(por_hi), .supply_below_por_lo(por_lo),
      .supply_below_bod_fall(bod_fall), .supply_above_bod_rise(bod_rise),
      .chip_enable, .brownout_disable, .brownout_irq_mode, .chip_en_irq_mode,
      .thermal_trip(rq[0]), .watchdog_req(rq[1]),
      .indep_watchdog_req(rq[2]), .sys_reset_req(rq[3]),
      .net_watchdog_req(rq[4]), .net_reset_core_only(rq[5]),
      .debug_req(rq[6]), .debug_reset_other(rq[7]),
      .net_sys_reset_req(rq[8]), .debug_from_net(rq[9]), .sleep_req,
      .sleep_wake_in, .sleep_wake_en, .ipc_wake_src, .timer_wake_in,
      .deep_wake_in, .deep_wake_en, .uart_rx_byte, .log_rx_byte,
      .module_clk_gate, .cpu_pll_sel, .hsp_pll_sel, .power_mode_r,
      .brownout_irq_r, .last_cause_r, .cold_boot_r, .core_power_on_r,
      .core_clk_on_r, .sram_retain_r, .sram_power_on_r, .soc_power_on_r,
      .system_on_domain_power_on_r, .module_clk_en_r, .cpu_clk_src_r, .hsp_clk_src_r,
      .uart_byte_keep, .log_byte_keep, .uart_wake_overflow(uart_ovf),
      .log_wake_overflow(log_ovf), .whole_chip_reset_n(scope[5]),
      .sys_periph_reset_n(scope[4]), .indep_wdg_reset_n(scope[3]),
      .i2c_pinmux_reset_n(scope[2]), .app_core_reset_n(scope[1]),
      .net_core_reset_n(scope[0]), .rtc_dom_reset_n);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(string nm, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic end_sim;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic to_mode(logic [1:0] r, logic [2:0] m);
      mode_q.push_back(m);
      sleep_req = r;
      cyc(1);
      sleep_req = 2'h0;
      cyc(6);
      check("mode", 16'(m), 16'(power_mode_r));
   endtask
   task automatic try_wake(logic [14:0] s, logic [3:0] i, logic [7:0] t,
                           logic [4:0] d, logic w);
      logic [2:0] m;
      m = w ? `MODE_ACTIVE : power_mode_r;
      if (w)
         mode_q.push_back(m);
      {sleep_wake_in, ipc_wake_src, timer_wake_in, deep_wake_in} = {s, i, t, d};
      cyc(10);
      check("wake mode", 16'(m), 16'(power_mode_r));
      {sleep_wake_in, ipc_wake_src, timer_wake_in, deep_wake_in} = '0;
      cyc(2);
   endtask
   task automatic bytes(int n, logic lg);
      repeat (n) begin
         {log_rx_byte, uart_rx_byte} = lg ? 2'h2 : 2'h1;
         cyc(2);
         {log_rx_byte, uart_rx_byte} = 2'h0;
         cyc(2);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // Waking step consumes no note
   always @(negedge clk) begin
      if (reset_n && power_mode_r !== prev_mode && mode_q.size() > 0
          && power_mode_r !== `MODE_WAKING)
         check("mode event", 16'(mode_q.pop_front()), 16'(power_mode_r));
      if (reset_n === 1'h1) begin
         kept_u += int'(uart_byte_keep === 1'h1);
         kept_l += int'(log_byte_keep === 1'h1);
      end
      prev_mode <= power_mode_r;
   end
   initial begin
      #400000;
      num_errors++;
      end_sim();
   end
   initial begin
      {rq, sleep_req, sleep_wake_in, ipc_wake_src, timer_wake_in} = '0;
      {deep_wake_in, uart_rx_byte, log_rx_byte, brownout_disable} = '0;
      {brownout_irq_mode, chip_en_irq_mode, hsp_pll_sel, cpu_pll_sel} = '0;
      {reset_n, rtc_reset_n, chip_enable, module_clk_gate} = '0;
      chip_enable = 1'h1;
      sleep_wake_en = 15'h7F9F;
      deep_wake_en = 5'h1F;
      level = 300;
      void'($urandom(32'hCE062D2A));
      cyc(16);
      {reset_n, rtc_reset_n} = 2'h3;
      cyc(8);
      check("cause", `CAUSE_POR, last_cause_r);
      module_clk_gate = 16'($urandom);
      {hsp_pll_sel, cpu_pll_sel} = 2'($urandom);
      cyc(6);
      check("clk en", ~module_clk_gate, module_clk_en_r);
      check("hsp src", 16'(hsp_pll_sel), 16'(hsp_clk_src_r));
      to_mode(2'h2, `MODE_SLEEP_CG);
      try_wake(15'h0000, 4'hE, 8'h00, 5'h00, 1'h0);
      try_wake(15'h0000, 4'h0, 8'hF0, 5'h00, 1'h0);
      try_wake(15'h0000, 4'h0, 8'h08, 5'h00, 1'h1);
      to_mode(2'h2, `MODE_SLEEP_CG);
      try_wake(15'h2000, 4'h0, 8'h00, 5'h00, 1'h1);
      to_mode(2'h1, `MODE_SLEEP_PG);
      try_wake(15'h6000, 4'h0, 8'h00, 5'h00, 1'h0);
      {kept_u, kept_l} = '0;
      bytes(70, 1'h0);
      bytes(40, 1'h1);
      check("uart kept", 16'h0040, 16'(kept_u));
      check("log kept", 16'h0020, 16'(kept_l));
      check("overflow", 16'h0003, 16'({uart_ovf, log_ovf}));
      try_wake(15'h0000, 4'h1, 8'h00, 5'h00, 1'h1);
      for (int b = 0; b < 5; b++) begin
         to_mode(2'h3, `MODE_DEEP_SLEEP);
         chip_en_irq_mode = 1'(b == 4);
         if (b == 0)
            try_wake(15'h7FFF, 4'hF, 8'hFF, 5'h10, 1'h0);
         try_wake(15'h0000, 4'h0, 8'h00, 5'(1 << b), 1'h1);
         check("deep_sleep_exit_reset cause", `CAUSE_DEEP_SLEEP_EXIT_RESET_EXIT, last_cause_r);
         check("cold boot", 16'h0001, 16'(cold_boot_r));
         check("cpu src", 16'(cpu_pll_sel), 16'(cpu_clk_src_r));
      end
      chip_en_irq_mode = 1'h0;
      for (int k = 0; k < 8; k++) begin
         rq = t_rq[k];
         cyc(8);
         check("scope", 16'(t_exp[k]), 16'(scope & t_msk[k]));
         if (t_cs[k] != 4'h0)
            check("cause", 16'(t_cs[k]), 16'(last_cause_r));
         rq = 10'h000;
         cyc(8);
         check("release", 16'h003F, 16'(scope));
      end
      {brownout_disable, level} = {1'h1, 180};
      cyc(8);
      check("bod off", 16'h0001, 16'(scope[4]));
      {brownout_disable, brownout_irq_mode} = 2'h1;
      cyc(8);
      check("bod irq", 16'h0003, 16'({brownout_irq_r, scope[4]}));
      brownout_irq_mode = 1'h0;
      cyc(8);
      check("bod rst", 16'h0000, 16'(scope[4]));
      check("bod cause", `CAUSE_BROWNOUT, last_cause_r);
      level = 210;
      cyc(10);
      check("bod hold", 16'h0000, 16'(scope[4]));
      level = 300;
      cyc(10);
      check("bod release", 16'h0001, 16'(scope[4]));
      chip_enable = 1'h0;
      cyc(8);
      check("ce reset", 16'h0001, 16'({scope, rtc_dom_reset_n}));
      check("ce cause", `CAUSE_CHIP_EN, last_cause_r);
      chip_enable = 1'h1;
      cyc(12);
      rtc_reset_n = 1'h0;
      cyc(4);
      check("rtc", 16'h007E, 16'({scope, rtc_dom_reset_n}));
      rtc_reset_n = 1'h1;
      level = 50;
      cyc(8);
      check("por", 16'h0000, 16'(scope[5]));
      check("por cause", `CAUSE_POR, last_cause_r);
      level = 300;
      cyc(20);
      check("por release", 16'h003F, 16'(scope));
      end_sim();
   end
endmodule // power_reset_wake_control_tb
bind power_reset_wake_control pwr_props chk_u (.*);
